/* logic/pig_top.sv */
// Interrupt enable gating with status latching and Wishbone access
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Speed change reaches the pending flag only while its enable bit is 1.
// - Cable diagnostics is gated by its own enable bit, 1 passes and 0 blocks.
// - Loss of management-serial sync counts only when its enable bit is 1.
// - Autonegotiation status change is gated by its own enable bit.
// - Frame checker/generator has a separate enable bit, 1 passes and 0 blocks.
// - Page received interrupts only when its enable bit is 1.
// - Idle error counter saturation interrupts only when its enable bit is 1.
// - MAC FIFO over/underflow is gated by an enable bit.
// - Receive status change interrupts only when its enable bit is 1.
// - Link status change interrupts only when its enable bit is 1.
// - The interrupt pin is driven only when the pin enable bit 0 (reset 0) is 1.
// - With the pin enabled, the pin asserts whenever any enabled source fires.
// - Status bits latch high on events and a status read clears them all together.
// - Status bits latch even for disabled sources; only enabled ones form pending.
// - Status bit 0 is a pending flag that latches on an enabled event until read.
module pig_top
  import pig_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Source event pins
  input wire logic [9:0] src_evt_i,
  // Interrupt pin and wrapper interrupt
  output logic int_n_o,
  output logic int_n_oe_o,
  output logic irq_o
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [15:0] src_en;
    logic pin_en;
    logic [15:0] status;
    logic [1:0] wrap_en;
    logic [1:0] wrap_st;
    logic [31:0] dat;
    logic ack;
    logic err;
    logic int_n;
    logic int_oe;
    logic irq;
  } pig_state_t;

  pig_state_t st_reg, st_next;

  pig_evt_if evt_bus();

  pig_evt_sync #(
    .N(PIG_NSRC)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(src_evt_i),
    .ev(evt_bus.src)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [15:0] pig_wr16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Place the ten source events on their status bit positions
  function automatic logic [15:0] pig_map(input logic [9:0] e);
    logic [15:0] m;
    m = '0;
    m[PIG_BIT_SPEED] = e[0];
    m[PIG_BIT_LINK] = e[1];
    m[PIG_BIT_RXSTAT] = e[2];
    m[PIG_BIT_FIFO] = e[3];
    m[PIG_BIT_IDLE] = e[4];
    m[PIG_BIT_PAGE] = e[5];
    m[PIG_BIT_FCFG] = e[6];
    m[PIG_BIT_ANEG] = e[7];
    m[PIG_BIT_SYNC] = e[8];
    m[PIG_BIT_CABLE] = e[9];
    return m;
  endfunction

  // ********************************************************************
  // Next state
  // ********************************************************************
  logic [15:0] ev_bits;
  logic [15:0] gated;
  logic any_en;
  logic req;
  logic rd_status;
  logic mapped;

  always_comb begin
    st_next = st_reg;
    ev_bits = pig_map(evt_bus.evt);
    req = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
    rd_status = req && !wb_we_i && (wb_adr_i == PIG_OFF_STATUS);
    mapped = 1'b1;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    st_next.dat = '0;

    // Per-source gates; bits for events of disabled sources are stored but never forwarded
    gated = ev_bits & st_reg.src_en;
    gated[PIG_BIT_SPEED] = ev_bits[PIG_BIT_SPEED] & st_reg.src_en[PIG_BIT_SPEED];
    gated[PIG_BIT_CABLE] = ev_bits[PIG_BIT_CABLE] & st_reg.src_en[PIG_BIT_CABLE];
    gated[PIG_BIT_SYNC] = ev_bits[PIG_BIT_SYNC] & st_reg.src_en[PIG_BIT_SYNC];
    gated[PIG_BIT_ANEG] = ev_bits[PIG_BIT_ANEG] & st_reg.src_en[PIG_BIT_ANEG];
    gated[PIG_BIT_FCFG] = ev_bits[PIG_BIT_FCFG] & st_reg.src_en[PIG_BIT_FCFG];
    gated[PIG_BIT_PAGE] = ev_bits[PIG_BIT_PAGE] & st_reg.src_en[PIG_BIT_PAGE];
    gated[PIG_BIT_IDLE] = ev_bits[PIG_BIT_IDLE] & st_reg.src_en[PIG_BIT_IDLE];
    gated[PIG_BIT_FIFO] = ev_bits[PIG_BIT_FIFO] & st_reg.src_en[PIG_BIT_FIFO];
    gated[PIG_BIT_RXSTAT] = ev_bits[PIG_BIT_RXSTAT] & st_reg.src_en[PIG_BIT_RXSTAT];
    gated[PIG_BIT_LINK] = ev_bits[PIG_BIT_LINK] & st_reg.src_en[PIG_BIT_LINK];
    gated[PIG_BIT_PENDING] = 1'b0;
    any_en = |gated;

    // Register reads; a status read returns the value before its own clear
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        PIG_OFF_SRC_EN: st_next.dat = {16'h0000, st_reg.src_en};
        PIG_OFF_PIN_EN: st_next.dat = {31'h00000000, st_reg.pin_en};
        PIG_OFF_STATUS: st_next.dat = {16'h0000, st_reg.status};
        PIG_OFF_WRAP_EN: st_next.dat = {30'h00000000, st_reg.wrap_en};
        PIG_OFF_WRAP_ST: st_next.dat = {30'h00000000, st_reg.wrap_st};
        PIG_OFF_WRAP_CLR: st_next.dat = '0;
        default: mapped = 1'b0;
      endcase
    end

    // Register writes
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        PIG_OFF_SRC_EN: begin
          st_next.src_en = pig_wr16(st_reg.src_en, wb_dat_i, wb_sel_i);
          st_next.src_en[15:11] = '0;
          st_next.src_en[0] = 1'b0;
        end
        PIG_OFF_PIN_EN: begin
          if (wb_sel_i[0]) begin
            st_next.pin_en = wb_dat_i[PIG_BIT_PIN_EN];
          end
        end
        PIG_OFF_WRAP_EN: begin
          if (wb_sel_i[0]) begin
            st_next.wrap_en = wb_dat_i[1:0];
          end
        end
        PIG_OFF_WRAP_CLR: begin
          if (wb_sel_i[0]) begin
            st_next.wrap_st = st_reg.wrap_st & ~wb_dat_i[1:0];
          end
        end
        PIG_OFF_STATUS, PIG_OFF_WRAP_ST: begin
          st_next.src_en = st_reg.src_en;
        end
        default: mapped = 1'b0;
      endcase
    end

    // Status latching: read clears all, a same-cycle event still sets its bit
    if (rd_status) begin
      st_next.status = '0;
    end
    st_next.status = st_next.status | ev_bits;
    if (any_en) begin
      st_next.status[PIG_BIT_PENDING] = 1'b1;
    end

    // Wrapper sticky events: bit 0 pending rose, bit 1 status read; set beats clear
    if (any_en && !st_reg.status[PIG_BIT_PENDING]) begin
      st_next.wrap_st[0] = 1'b1;
    end
    if (rd_status) begin
      st_next.wrap_st[1] = 1'b1;
    end
    st_next.irq = |(st_next.wrap_st & st_reg.wrap_en);

    // Pin: asserted low from the pending flag, released high when disabled
    st_next.int_n = !(st_reg.pin_en && st_next.status[PIG_BIT_PENDING]);
    st_next.int_oe = st_reg.pin_en;

    if (req) begin
      st_next.ack = mapped;
      st_next.err = !mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{src_en: PIG_RST_SRC_EN, pin_en: PIG_RST_PIN_EN, status: PIG_RST_STATUS,
                  wrap_en: PIG_RST_WRAP, wrap_st: PIG_RST_WRAP, dat: '0, ack: 1'b0, err: 1'b0,
                  int_n: 1'b1, int_oe: 1'b0, irq: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign wb_err_o = st_reg.err;
  assign int_n_o = st_reg.int_n;
  assign int_n_oe_o = st_reg.int_oe;
  assign irq_o = st_reg.irq;

endmodule
`default_nettype wire

/* logic/pig_pkg.sv */
// Package for the interrupt enable gating block: offsets, layouts, reset values
package pig_pkg;

  // ********************************************************************
  // Source count and status bit positions
  // ********************************************************************
  localparam int PIG_NSRC = 10;
  localparam int PIG_BIT_PENDING = 0;
  localparam int PIG_BIT_SPEED = 1;
  localparam int PIG_BIT_LINK = 2;
  localparam int PIG_BIT_RXSTAT = 3;
  localparam int PIG_BIT_FIFO = 4;
  localparam int PIG_BIT_IDLE = 5;
  localparam int PIG_BIT_PAGE = 6;
  localparam int PIG_BIT_FCFG = 7;
  localparam int PIG_BIT_ANEG = 8;
  localparam int PIG_BIT_SYNC = 9;
  localparam int PIG_BIT_CABLE = 10;
  localparam int PIG_BIT_PIN_EN = 0;

  // ********************************************************************
  // Wishbone register byte offsets
  // ********************************************************************
  localparam logic [7:0] PIG_OFF_SRC_EN = 8'h00;
  localparam logic [7:0] PIG_OFF_PIN_EN = 8'h04;
  localparam logic [7:0] PIG_OFF_STATUS = 8'h08;
  localparam logic [7:0] PIG_OFF_WRAP_EN = 8'h0C;
  localparam logic [7:0] PIG_OFF_WRAP_CLR = 8'h10;
  localparam logic [7:0] PIG_OFF_WRAP_ST = 8'h14;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [15:0] PIG_RST_SRC_EN = 16'h0000;
  localparam logic PIG_RST_PIN_EN = 1'b0;
  localparam logic [15:0] PIG_RST_STATUS = 16'h0000;
  localparam logic [1:0] PIG_RST_WRAP = 2'h0;
  localparam logic [2:0] PIG_RST_SYNC = 3'h0;

endpackage

/* logic/pig_evt_if.sv */
// Interface carrying source events between the pin conditioner and the core
`timescale 1ns/10ps
`default_nettype none
interface pig_evt_if;
  logic [9:0] evt;
  modport src (output evt);
  modport dst (input evt);
endinterface
`default_nettype wire

/* logic/pig_evt_sync.sv */
// Three-flop conditioner turning asynchronous source levels into one-cycle events
`timescale 1ns/10ps
`default_nettype none
module pig_evt_sync
  import pig_pkg::*;
#(
  parameter int N = PIG_NSRC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw source pulses
  input wire logic [N-1:0] raw_i,
  // Events out
  pig_evt_if.src ev
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] seen;
  } pig_sync_t;

  pig_sync_t st_reg, st_next;

  // Change counts once the second and third stage agree; first stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = raw_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < N; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.seen[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Rising edge of the agreed level is the event
  assign ev.evt = st_next.seen & ~st_reg.seen;

endmodule
`default_nettype wire

/* sim/pig_top_sva.sv */
// Checker for the interrupt gating block ports
`timescale 1ns/10ps
`default_nettype none
module pig_top_sva
  import pig_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Interrupt outputs
  input wire logic int_n_o,
  input wire logic int_n_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic mapped;
  logic rd_st;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i[1:0] == 2'h0;
  assign mapped = wb_adr_i <= PIG_OFF_WRAP_ST;
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == PIG_OFF_STATUS;
  property p_answer; req |=> wb_ack_o == mapped && wb_err_o == !mapped; endproperty
  a_answer: assert property (p_answer) else $error("bus answer wrong");
  property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_pin_off; !int_n_oe_o |-> int_n_o; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin low while disabled");
  property p_rst_out; $past(rst_i) |-> int_n_o && !int_n_oe_o && !irq_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
  property p_fell_pin; $fell(int_n_o) |-> int_n_oe_o; endproperty
  a_fell_pin: assert property (p_fell_pin) else $error("pin asserted without enable");
  // Pin may only let go at a taken request or its answer, since a read or write is the only release
  property p_pin_hold;
    !int_n_o && int_n_oe_o && !wb_ack_o && !(wb_cyc_i && wb_stb_i) |=> !int_n_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin released without read");
  property p_st_read; rd_st |-> wb_dat_o[31:11] == 21'h0 && (!wb_dat_o[0] || |wb_dat_o[10:1]); endproperty
  a_st_read: assert property (p_st_read) else $error("status read inconsistent");
  c_pin: cover property (!int_n_o);
  c_err: cover property (wb_err_o);
  c_irq: cover property (irq_o);
endmodule
bind pig_top pig_top_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o), .irq_o(irq_o));
`default_nettype wire

/* sim/pig_host_model.sv */
// Host side model watching the active-low interrupt pin
`timescale 1ns/10ps
`default_nettype none
module pig_host_model (
  // Pin from the device
  input wire logic int_n_i,
  input wire logic int_n_oe_i,
  // Seen by the host
  output logic pin_o,
  output logic service_o
);
  // Board pull-up holds the line high when the device lets go
  assign pin_o = int_n_oe_i ? int_n_i : 1'b1;
  // Host goes to read status whenever the line is low
  assign service_o = !pin_o;
endmodule
`default_nettype wire

/* sim/pig_top_tb_top.sv */
// Self-checking bench for the interrupt gating block
`timescale 1ns/10ps
`default_nettype none
module pig_top_tb_top;
  import pig_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic [9:0] evt = 10'h000;
  logic [3:0] sel = 4'h3;
  logic ack, err, int_n, oe, irq, pin, svc;
  int mismatches = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int seed = 32'h9C9F6B48;
  pig_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .src_evt_i(evt), .int_n_o(int_n), .int_n_oe_o(oe), .irq_o(irq));
  pig_host_model host (.int_n_i(int_n), .int_n_oe_i(oe), .pin_o(pin), .service_o(svc));
  initial forever #20 clk_i = ~clk_i;
  // Whole run needs well under a thousand cycles per source pass
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("Tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Classic single cycle; the answer edge is the only place data is taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    rdat = dat_o;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Level held long enough to pass the synchroniser, then dropped
  task automatic fire(input int k);
    evt[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    evt[k] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic [31:0] exp_st(input int k, input logic [9:0] en);
    exp_st = 32'h0;
    exp_st[k+1] = 1'b1;
    exp_st[0] = en[k];
  endfunction
  initial begin
    logic e;
    logic [9:0] m;
    logic pe;
    int k;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'h1, {oe, pin});
    bus(1'b1, PIG_OFF_STATUS, 32'h0000FFFF, e);
    for (int a = 0; a <= 8; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, e);
      chk(32'h0, rdat);
    end
    bus(1'b0, 8'h40, 32'h0, e);
    chk(32'h1, e);
    $display("Reset and map test done");
    for (int i = 0; i < 20; i++) begin
      k = i % 10;
      m = 10'($random(seed));
      m[k] = (i < 10);
      pe = (i < 10) || 1'($random(seed));
      bus(1'b1, PIG_OFF_SRC_EN, {21'h0, m, 1'b0}, e);
      bus(1'b1, PIG_OFF_PIN_EN, {31'h0, pe}, e);
      fire(k);
      chk(!(m[k] && pe), pin);
      chk(pe, oe);
      bus(1'b0, PIG_OFF_STATUS, 32'h0, e);
      chk(exp_st(k, m), rdat);
      bus(1'b0, PIG_OFF_STATUS, 32'h0, e);
      chk(32'h0, rdat);
      chk(32'h0, svc);
      $display("Source test %0d done", i);
    end
    bus(1'b1, PIG_OFF_WRAP_CLR, 32'h3, e);
    bus(1'b1, PIG_OFF_WRAP_EN, 32'h1, e);
    bus(1'b1, PIG_OFF_SRC_EN, 32'h7FE, e);
    fire(3);
    chk(32'h1, irq);
    bus(1'b1, PIG_OFF_WRAP_EN, 32'h0, e);
    chk(32'h0, irq);
    bus(1'b1, PIG_OFF_WRAP_CLR, 32'h1, e);
    bus(1'b0, PIG_OFF_WRAP_ST, 32'h0, e);
    chk(32'h0, rdat[0]);
    bus(1'b1, PIG_OFF_WRAP_EN, 32'h1, e);
    chk(32'h0, irq);
    // Upper lane alone: enable bits 10:8 clear, lower lane untouched
    sel <= 4'h2;
    bus(1'b1, PIG_OFF_SRC_EN, 32'h0, e);
    sel <= 4'h3;
    bus(1'b0, PIG_OFF_SRC_EN, 32'h0, e);
    chk(32'h0FE, rdat);
    $display("Wrapper test done");
    give_verdict();
  end
endmodule
`default_nettype wire
